// File: rtcpc_calendar.sv
// Internal BCD time counter with month length and leap year handling.
`timescale 1ns/10ps
module rtcpc_calendar
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        tick,
  input  wire logic        load,
  input  wire logic [63:0] load_value,
  output logic      [63:0] count
);

  // Binary value of a BCD byte.
  function automatic logic [6:0] bcd_bin(input logic [7:0] v);
    bcd_bin = 7'(v[7:4] * 4'ha + v[3:0]);
  endfunction : bcd_bin

  // Next BCD value, wrapping to lo once hi has been reached.
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] hi,
                                          input logic [7:0] lo);
    if (v >= hi)
      bcd_step = lo;
    else if (v[3:0] == 4'h9)
      bcd_step = {4'(v[7:4] + 4'h1), 4'h0};
    else
      bcd_step = {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction : bcd_step

  logic [7:0] sec, min, hour, dow, date, month, year, cent;
  logic [6:0] yr_bin, ce_bin;
  logic       leap;
  logic [7:0] last_day;
  logic       end_min, end_hour, end_day, end_month, end_year, end_cent;

  assign {cent, year, month, date, dow, hour, min, sec} = count;
  assign yr_bin = bcd_bin(year);
  assign ce_bin = bcd_bin(cent);

  // Year 00 is leap only in a century divisible by four, so 2100 is not.
  assign leap     = (yr_bin[1:0] == 2'h0) && ((year != 8'h00) || (ce_bin[1:0] == 2'h0));
  assign last_day = (month == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                    ((month == 8'h04) || (month == 8'h06) || (month == 8'h09) ||
                     (month == 8'h11)) ? 8'h30 : 8'h31;
  assign end_min   = tick && (sec == 8'h59);
  assign end_hour  = end_min && (min == 8'h59);
  assign end_day   = end_hour && (hour == 8'h23);
  assign end_month = end_day && (date >= last_day);
  assign end_year  = end_month && (month == 8'h12);
  assign end_cent  = end_year && (year == 8'h99);

  // Host loads take priority over counting so a freshly set time is not skipped.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count <= rtcpc_pkg::TIME_RESET;
    else if (load)
      count <= load_value;
    else if (tick)
      count <= {end_cent  ? bcd_step(cent, 8'h99, 8'h00) : cent,
                end_year  ? bcd_step(year, 8'h99, 8'h00) : year,
                end_month ? bcd_step(month, 8'h12, 8'h01) : month,
                end_day   ? bcd_step(date, last_day, 8'h01) : date,
                end_day   ? bcd_step(dow, 8'h07, 8'h01) : dow,
                end_hour  ? bcd_step(hour, 8'h23, 8'h00) : hour,
                end_min   ? bcd_step(min, 8'h59, 8'h00) : min,
                bcd_step(sec, 8'h59, 8'h00)};
  end

  // Feb 28 of a non leap year steps straight to March 1.
  feb_rollover_a: assert property (@(posedge clk) disable iff (!reset_n)
    (tick && !load && !leap && month == 8'h02 && date == 8'h28 && end_day)
      |=> (count[47:32] == 16'h0301))
    else $error("February did not roll to March in a common year.");

endmodule : rtcpc_calendar

// File: rtcpc_host.sv
// Host processor model that drives the bytewide bus of the clock block.
`timescale 1ns/10ps
module rtcpc_host
(
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_oe,
  output logic            cs_n,
  output logic            oe_n,
  output logic            we_n,
  output logic      [4:0] addr,
  output logic      [7:0] wr_data
);
  // The bus starts idle; released data lines later carry the inverse of the last byte.
  initial
  begin
    cs_n    = 1'b1;
    oe_n    = 1'b1;
    we_n    = 1'b1;
    addr    = 5'h00;
    wr_data = 8'h00;
  end

  // One byte write, held long enough to pass the pin filter, then a quiet gap.
  task automatic write_byte(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr    = a;
    wr_data = d;
    cs_n    = 1'b0;
    we_n    = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    cs_n    = 1'b1;
    we_n    = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    wr_data = ~d;
  endtask : write_byte

  // One byte read; data is taken at the edge where the device is seen driving.
  task automatic read_byte(input logic [4:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(posedge clk);
    #1;
    addr = a;
    cs_n = 1'b0;
    oe_n = 1'b0;
    ok   = 1'b0;
    d    = 8'h00;
    for (n = 0; n < 12 && !ok; n++)
    begin
      @(posedge clk);
      ok = (rd_oe === 1'b1);
      d  = rd_data;
    end
    #1;
    cs_n = 1'b1;
    oe_n = 1'b1;
    repeat (8) @(posedge clk);
  endtask : read_byte
endmodule : rtcpc_host

// File: rtcpc_pkg.sv
// Shared constants for the bytewide clock, alarm and power control block.
package rtcpc_pkg;

  // System clock rate and the times that are turned into cycle counts.
  localparam int          CLK_HZ          = 125_000_000;
  localparam int          SQW_HZ          = 32_768;
  localparam int          RST_HOLD_MS     = 40;
  localparam int          SECOND_S        = 1;
  localparam int          SQW_HALF_CYCLES = CLK_HZ / (2 * SQW_HZ);
  localparam int          SECOND_CYCLES   = CLK_HZ * SECOND_S;
  localparam int          RST_HOLD_CYCLES = (CLK_HZ / 1000) * RST_HOLD_MS;

  // Register locations on the five address lines.
  localparam logic [4:0]  REG_SEC         = 5'h00;
  localparam logic [4:0]  REG_CENTURY     = 5'h07;
  localparam logic [4:0]  REG_ALM_SEC     = 5'h08;
  localparam logic [4:0]  REG_ALM_MIN     = 5'h09;
  localparam logic [4:0]  REG_ALM_HOUR    = 5'h0a;
  localparam logic [4:0]  REG_ALM_DATE    = 5'h0b;
  localparam logic [4:0]  REG_WDOG_LO     = 5'h0c;
  localparam logic [4:0]  REG_WDOG_HI     = 5'h0d;
  localparam logic [4:0]  REG_CTRL_A      = 5'h0e;
  localparam logic [4:0]  REG_CTRL_B      = 5'h0f;
  localparam logic [4:0]  REG_RAM_ADDR    = 5'h10;
  localparam logic [4:0]  REG_RAM_DATA    = 5'h11;

  // Control A fields.
  localparam int          CA_ALARM_EN     = 0;
  localparam int          CA_WDOG_EN      = 1;
  localparam int          CA_KICK_EN      = 2;
  localparam int          CA_TO_RESET     = 3;
  localparam int          CA_PWR_KICK     = 4;
  localparam int          CA_PWR_ALARM    = 5;
  localparam int          CA_SQW_EN       = 6;
  localparam int          CA_OSC_STOP     = 7;

  // Control B fields.
  localparam int          CB_VIEW_ON      = 0;
  localparam int          CB_PWR_RELEASE  = 1;
  localparam int          CB_FLAG_LO      = 4;

  // Reset values and the alarm don't-care bit.
  localparam logic [7:0]  CTRL_A_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_B_RESET    = 8'h01;
  localparam int          ALM_MASK_BIT    = 7;
  localparam logic [63:0] TIME_RESET      = 64'h20_00_01_01_01_00_00_00;

endpackage : rtcpc_pkg

// File: rtcpc_top.sv
// Clock, calendar, alarm, watchdog, power control and user RAM behind a bytewide port.
// What this block does
// - BCD calendar time with 24-hour hours.
// - Month lengths and leap years right through 2100.
// - Internal counting copy; host sees external copy only.
// - Host can freeze and resume external copy updates.
// - Internal copy keeps counting while oscillator runs.
// - Below trip level, host accesses are ignored.
// - Below trip level, SRAM select forced inactive.
// - Alarm, watchdog, kick drive interrupt or reset.
// - Kick or wake alarm requests power on.
// - Software releases the power on request.
// - Reset asserted on supply failure until recovery.
// - 256 bytes of user RAM via host port.
// - Square wave at crystal rate on request.
// - Read when selected without write; enables drive data.
// - Write while select and strobe both active.
// - Reset stays asserted 40 ms after supply returns.
// - View bit low freezes, high resumes within a second.
`timescale 1ns/10ps
module rtcpc_top
#(
  parameter int RAM_BYTES       = 256,
  parameter int SECOND_CYCLES   = rtcpc_pkg::SECOND_CYCLES,
  parameter int RST_HOLD_CYCLES = rtcpc_pkg::RST_HOLD_CYCLES
)
(
  input  wire logic       CLK_SYS,
  input  wire logic       RESET_N,
  input  wire logic       CHIP_SELECT_N,
  input  wire logic       OUTPUT_ENABLE_N,
  input  wire logic       WRITE_ENABLE_N,
  input  wire logic [4:0] REGISTER_SELECT_LINES,
  input  wire logic [7:0] BUS_BYTE_LINES_IN,
  output logic      [7:0] BUS_BYTE_LINES_OUT,
  output logic            BUS_BYTE_LINES_OE,
  input  wire logic       POWER_FAIL_TRIP_LEVEL,
  input  wire logic       KICK_INPUT_N,
  input  wire logic       SRAM_SELECT_IN_N,
  output logic            SRAM_SELECT_OUT_N,
  output logic            SQUARE_WAVE_OUT,
  output logic            INTERRUPT_N_OUT,
  output logic            INTERRUPT_N_OE,
  output logic            SYSTEM_RESET_N_OUT,
  output logic            SYSTEM_RESET_N_OE,
  output logic            POWER_ON_REQUEST_N_OUT,
  output logic            POWER_ON_REQUEST_N_OE
);

  localparam int          PIN_W    = 19;
  localparam int          RAM_AW   = $clog2(RAM_BYTES);
  localparam logic [10:0] SQW_HALF = 11'(rtcpc_pkg::SQW_HALF_CYCLES);

  // Pins pass three flops; a bit only moves once stages two and three agree.
  logic [PIN_W-1:0] pin_s1, pin_s2, pin_s3, pin;
  wire  [PIN_W-1:0] pin_raw  = {CHIP_SELECT_N, OUTPUT_ENABLE_N, WRITE_ENABLE_N,
                                REGISTER_SELECT_LINES, BUS_BYTE_LINES_IN,
                                KICK_INPUT_N, SRAM_SELECT_IN_N, POWER_FAIL_TRIP_LEVEL};
  wire  [PIN_W-1:0] next_pin = ((pin_s2 ~^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin);

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pin_s1 <= 19'h7ffff;
      pin_s2 <= 19'h7ffff;
      pin_s3 <= 19'h7ffff;
      pin    <= 19'h7ffff;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin    <= next_pin;
    end
  end

  wire       cs_n = pin[18];
  wire       oe_n = pin[17];
  wire       we_n = pin[16];
  wire [4:0] addr = pin[15:11];
  wire [7:0] din  = pin[10:3];
  wire       kick_n = pin[2];
  wire       sram_in_n = pin[1];
  wire       power_fail = pin[0];

  // Host register file: time view, alarm, watchdog reload and controls.
  logic [7:0]        host_reg [0:15];
  logic [7:0]        ram [0:RAM_BYTES-1];
  logic [RAM_AW-1:0] ram_ptr;
  logic [7:0]        wr_data;
  logic [4:0]        wr_addr;
  logic              write_seen, view_dirty, view_on_q;
  logic [2:0]        flags;
  logic              pwr_request;
  logic [63:0]       time_count;

  wire [7:0] ctrl_a   = host_reg[rtcpc_pkg::REG_CTRL_A[3:0]];
  wire       view_on  = host_reg[rtcpc_pkg::REG_CTRL_B[3:0]][rtcpc_pkg::CB_VIEW_ON];
  wire       write_on = !cs_n && !we_n && !power_fail;
  wire       commit   = write_seen && !write_on && !power_fail;
  wire       read_on  = !cs_n && we_n && !oe_n && !power_fail;
  wire       wr_low   = commit && (wr_addr < rtcpc_pkg::REG_RAM_ADDR);
  wire       wr_time  = wr_low && (wr_addr <= rtcpc_pkg::REG_CENTURY);
  wire       wr_ctlb  = commit && (wr_addr == rtcpc_pkg::REG_CTRL_B);
  wire       wr_wdog  = commit && ((wr_addr == rtcpc_pkg::REG_WDOG_LO) ||
                                   (wr_addr == rtcpc_pkg::REG_WDOG_HI));
  wire       load_int = view_dirty && view_on && !wr_time;
  wire       copy_out = view_on && !view_dirty && !wr_low;
  wire [7:0] ctlb_view = {1'b0, flags, 3'h0, view_on};

  // Read selection; RAM sits behind a pointer so five address lines reach it all.
  wire [7:0] read_byte = (addr == rtcpc_pkg::REG_CTRL_B) ? ctlb_view :
                         (addr < rtcpc_pkg::REG_RAM_ADDR) ? host_reg[addr[3:0]] :
                         (addr == rtcpc_pkg::REG_RAM_ADDR) ? 8'(ram_ptr) :
                         (addr == rtcpc_pkg::REG_RAM_DATA) ? ram[ram_ptr] : 8'h00;

  // Writes land when the earlier of select and strobe releases, using the held data.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      write_seen <= 1'b0;
      wr_addr    <= 5'h00;
      wr_data    <= 8'h00;
      ram_ptr    <= '0;
      view_dirty <= 1'b0;
      view_on_q  <= 1'b1;
      for (int i = 0; i < 16; i++)
        host_reg[i] <= 8'h00;
      host_reg[rtcpc_pkg::REG_CTRL_A[3:0]] <= rtcpc_pkg::CTRL_A_RESET;
      host_reg[rtcpc_pkg::REG_CTRL_B[3:0]] <= rtcpc_pkg::CTRL_B_RESET;
    end
    else
    begin
      write_seen <= write_on;
      view_on_q  <= view_on;
      if (write_on)
      begin
        wr_addr <= addr;
        wr_data <= din;
      end
      if (wr_low)
        host_reg[wr_addr[3:0]] <= wr_data;
      if (copy_out)
        for (int i = 0; i < 8; i++)
          host_reg[i] <= time_count[8*i +: 8];
      if (wr_time)
        view_dirty <= 1'b1;
      else if (load_int)
        view_dirty <= 1'b0;
      if (commit && wr_addr == rtcpc_pkg::REG_RAM_ADDR)
        ram_ptr <= RAM_AW'(wr_data);
      else if ((commit && wr_addr == rtcpc_pkg::REG_RAM_DATA) ||
               (read_on && !BUS_BYTE_LINES_OE && addr == rtcpc_pkg::REG_RAM_DATA))
        ram_ptr <= RAM_AW'(ram_ptr + 1'b1);
    end
  end

  // User RAM has no reset, like battery backed storage.
  always_ff @(posedge CLK_SYS)
  begin
    if (commit && wr_addr == rtcpc_pkg::REG_RAM_DATA)
      ram[ram_ptr] <= wr_data;
  end

  // One second enable and the square wave divider, both stopped with the oscillator.
  logic [31:0] sec_cnt;
  logic [10:0] sqw_cnt;
  logic        sqw_level;
  wire         osc_run  = !ctrl_a[rtcpc_pkg::CA_OSC_STOP];
  wire         sec_tick = osc_run && (sec_cnt == 32'(SECOND_CYCLES - 1));
  wire         sqw_flip = osc_run && (sqw_cnt == SQW_HALF - 11'h001);

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sec_cnt   <= 32'h0;
      sqw_cnt   <= 11'h000;
      sqw_level <= 1'b0;
    end
    else if (osc_run)
    begin
      sec_cnt   <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
      sqw_cnt   <= sqw_flip ? 11'h000 : sqw_cnt + 11'h001;
      sqw_level <= sqw_level ^ sqw_flip;
    end
  end

  rtcpc_calendar u_calendar
  (
    .clk        (CLK_SYS),
    .reset_n    (RESET_N),
    .tick       (sec_tick),
    .load       (load_int),
    .load_value ({host_reg[7], host_reg[6], host_reg[5], host_reg[4],
                  host_reg[3], host_reg[2], host_reg[1], host_reg[0]}),
    .count      (time_count)
  );

  // Alarm fields with bit seven set are don't-care; the match is taken on its first cycle.
  function automatic logic field_hit(input logic [7:0] alarm, input logic [7:0] now);
    field_hit = alarm[rtcpc_pkg::ALM_MASK_BIT] || (alarm == now);
  endfunction : field_hit

  logic        alarm_q, kick_q, wdog_load;
  logic [15:0] wdog_cnt;
  wire alarm_hit = field_hit(host_reg[rtcpc_pkg::REG_ALM_SEC[3:0]], time_count[7:0]) &&
                   field_hit(host_reg[rtcpc_pkg::REG_ALM_MIN[3:0]], time_count[15:8]) &&
                   field_hit(host_reg[rtcpc_pkg::REG_ALM_HOUR[3:0]], time_count[23:16]) &&
                   field_hit(host_reg[rtcpc_pkg::REG_ALM_DATE[3:0]], time_count[39:32]);
  wire alarm_ev  = alarm_hit && !alarm_q;
  wire kick_ev   = !kick_n && kick_q;
  wire wdog_ev   = sec_tick && (wdog_cnt == 16'h0001);
  wire [2:0] events  = {kick_ev, wdog_ev, alarm_ev};
  wire [2:0] clr     = wr_ctlb ? wr_data[rtcpc_pkg::CB_FLAG_LO +: 3] : 3'h0;
  wire [2:0] enabled = flags & ctrl_a[rtcpc_pkg::CA_KICK_EN:rtcpc_pkg::CA_ALARM_EN];
  wire       to_rst  = ctrl_a[rtcpc_pkg::CA_TO_RESET];
  wire       pwr_set = (kick_ev && ctrl_a[rtcpc_pkg::CA_PWR_KICK]) ||
                       (alarm_ev && ctrl_a[rtcpc_pkg::CA_PWR_ALARM]);
  wire       pwr_clr = wr_ctlb && wr_data[rtcpc_pkg::CB_PWR_RELEASE];

  // Event flags, watchdog and power request; a new event beats a clear in the same cycle.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      alarm_q     <= 1'b1;
      kick_q      <= 1'b1;
      wdog_cnt    <= 16'h0000;
      wdog_load   <= 1'b0;
      flags       <= 3'h0;
      pwr_request <= 1'b0;
    end
    else
    begin
      alarm_q     <= alarm_hit;
      kick_q      <= kick_n;
      // Reload one cycle after the commit, once the new byte sits in the register.
      wdog_load   <= wr_wdog;
      flags       <= (flags & ~clr) | events;
      pwr_request <= pwr_set || (pwr_request && !pwr_clr);
      if (wdog_load || wdog_ev)
        wdog_cnt <= {host_reg[rtcpc_pkg::REG_WDOG_HI[3:0]], host_reg[rtcpc_pkg::REG_WDOG_LO[3:0]]};
      else if (sec_tick && wdog_cnt != 16'h0000)
        wdog_cnt <= wdog_cnt - 16'h0001;
    end
  end

  // Power-on reset stretch: the counter reloads for as long as the supply is low.
  logic [31:0] hold_cnt;
  wire         hold_on = (hold_cnt != 32'h0);

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      hold_cnt <= 32'(RST_HOLD_CYCLES);
    else if (power_fail)
      hold_cnt <= 32'(RST_HOLD_CYCLES);
    else if (hold_on)
      hold_cnt <= hold_cnt - 32'h1;
  end

  // All pin outputs are registered; open-drain lines only ever drive low.
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      BUS_BYTE_LINES_OUT     <= 8'h00;
      BUS_BYTE_LINES_OE      <= 1'b0;
      SRAM_SELECT_OUT_N      <= 1'b1;
      SQUARE_WAVE_OUT        <= 1'b0;
      INTERRUPT_N_OUT        <= 1'b0;
      INTERRUPT_N_OE         <= 1'b0;
      SYSTEM_RESET_N_OUT     <= 1'b0;
      SYSTEM_RESET_N_OE      <= 1'b1;
      POWER_ON_REQUEST_N_OUT <= 1'b0;
      POWER_ON_REQUEST_N_OE  <= 1'b0;
    end
    else
    begin
      BUS_BYTE_LINES_OUT     <= read_byte;
      BUS_BYTE_LINES_OE      <= read_on;
      SRAM_SELECT_OUT_N      <= sram_in_n || power_fail;
      SQUARE_WAVE_OUT        <= sqw_level && ctrl_a[rtcpc_pkg::CA_SQW_EN];
      INTERRUPT_N_OE         <= !to_rst && (enabled != 3'h0);
      SYSTEM_RESET_N_OE      <= power_fail || hold_on || (to_rst && enabled != 3'h0);
      POWER_ON_REQUEST_N_OE  <= pwr_request;
    end
  end

  sram_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    power_fail |=> SRAM_SELECT_OUT_N)
    else $error("SRAM select passed through while supply was low.");

  bus_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    power_fail |=> !BUS_BYTE_LINES_OE)
    else $error("Data lines driven while supply was low.");

  read_drive_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    BUS_BYTE_LINES_OE |-> $past(!cs_n && we_n && !oe_n))
    else $error("Data lines driven outside a read.");

  reset_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    $fell(power_fail) |-> ##1 SYSTEM_RESET_N_OE [*8])
    else $error("Reset released too soon after supply returned.");

  reset_fail_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    power_fail |=> SYSTEM_RESET_N_OE && hold_cnt == 32'(RST_HOLD_CYCLES))
    else $error("Reset not asserted during supply failure.");

  view_freeze_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (!view_on && !wr_low) |=> $stable(host_reg[0]))
    else $error("Frozen seconds view changed.");

  pwr_release_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (pwr_clr && !pwr_set) |=> ##1 !POWER_ON_REQUEST_N_OE)
    else $error("Power request not released by software.");

  kick_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (kick_ev && ctrl_a[rtcpc_pkg::CA_KICK_EN] && !to_rst) |=> ##1 INTERRUPT_N_OE)
    else $error("Kick event did not raise the interrupt.");

  resume_view_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (view_on && !view_on_q && !view_dirty) |=> (host_reg[0] == $past(time_count[7:0])))
    else $error("External view did not resume after unfreeze.");

endmodule : rtcpc_top

// File: rtcpc_top_tb.sv
// Self-checking bench for the clock, alarm and power control block.
`timescale 1ns/10ps
module rtcpc_top_tb;
  logic       clk_sys, reset_n, pf, kick_n, sram_in_n, ok;
  logic [7:0] d, s1;
  wire        cs_n, oe_n, we_n, doe, sram_out_n, square_wave_out, irq_out, irq_oe;
  wire        rst_out, rst_oe, pwr_out, pwr_oe;
  wire  [4:0] addr;
  wire  [7:0] din, dout;
  int         bad_count, cmp_count, n;

  rtcpc_top #(.RAM_BYTES(256), .SECOND_CYCLES(50), .RST_HOLD_CYCLES(20)) rtcpc_top_inst
  (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .CHIP_SELECT_N(cs_n), .OUTPUT_ENABLE_N(oe_n),
    .WRITE_ENABLE_N(we_n), .REGISTER_SELECT_LINES(addr), .BUS_BYTE_LINES_IN(din),
    .BUS_BYTE_LINES_OUT(dout), .BUS_BYTE_LINES_OE(doe), .POWER_FAIL_TRIP_LEVEL(pf),
    .KICK_INPUT_N(kick_n), .SRAM_SELECT_IN_N(sram_in_n), .SRAM_SELECT_OUT_N(sram_out_n),
    .SQUARE_WAVE_OUT(square_wave_out), .INTERRUPT_N_OUT(irq_out), .INTERRUPT_N_OE(irq_oe),
    .SYSTEM_RESET_N_OUT(rst_out), .SYSTEM_RESET_N_OE(rst_oe),
    .POWER_ON_REQUEST_N_OUT(pwr_out), .POWER_ON_REQUEST_N_OE(pwr_oe)
  );

  rtcpc_host rtcpc_host_inst
  (
    .clk(clk_sys), .rd_data(dout), .rd_oe(doe), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .wr_data(din)
  );

  // Compares one result; an unknown counts as a match only against the same unknown.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Waits for the reset output to let go; it must hold at least the programmed span.
  task automatic wait_release(input int lo);
    for (n = 0; n < 60 && rst_oe !== 1'b0; n++)
      @(posedge clk_sys);
    chk("reset hold long", 16'(n >= lo), 16'h0001);
    chk("reset released", {15'h0000, rst_oe}, 16'h0000);
  endtask : wait_release

  // A key press on the kick pin, long enough for the pin filter.
  task automatic kick;
    @(posedge clk_sys);
    #1 kick_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 kick_n = 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask : kick

  // Last RAM byte and first RAM byte, plus an unmapped address that reads zero.
  task automatic t_ram;
    rtcpc_host_inst.write_byte(5'h10, 8'hff);
    rtcpc_host_inst.write_byte(5'h11, 8'h5a);
    rtcpc_host_inst.write_byte(5'h10, 8'h00);
    rtcpc_host_inst.write_byte(5'h11, 8'ha5);
    rtcpc_host_inst.write_byte(5'h10, 8'hff);
    rtcpc_host_inst.read_byte(5'h11, d, ok);
    chk("ram ff", {8'h00, d}, 16'h005a);
    rtcpc_host_inst.read_byte(5'h11, d, ok);
    chk("ram 00", {8'h00, d}, 16'h00a5);
    rtcpc_host_inst.read_byte(5'h1f, d, ok);
    chk("unmapped", {8'h00, d}, 16'h0000);
    $display("ram test done");
  endtask : t_ram

  // Rolls 2100-02-28 23:59:59 over a non-leap month end, then freezes and resumes the view.
  task automatic t_calendar;
    rtcpc_host_inst.write_byte(5'h0f, 8'h00);
    rtcpc_host_inst.write_byte(5'h00, 8'h59);
    rtcpc_host_inst.write_byte(5'h01, 8'h59);
    rtcpc_host_inst.write_byte(5'h02, 8'h23);
    rtcpc_host_inst.write_byte(5'h04, 8'h28);
    rtcpc_host_inst.write_byte(5'h05, 8'h02);
    rtcpc_host_inst.write_byte(5'h06, 8'h00);
    rtcpc_host_inst.write_byte(5'h07, 8'h21);
    rtcpc_host_inst.write_byte(5'h0f, 8'h01);
    repeat (120) @(posedge clk_sys);
    rtcpc_host_inst.write_byte(5'h0f, 8'h00);
    rtcpc_host_inst.read_byte(5'h02, d, ok);
    chk("hour", {8'h00, d}, 16'h0000);
    rtcpc_host_inst.read_byte(5'h04, d, ok);
    chk("date", {8'h00, d}, 16'h0001);
    rtcpc_host_inst.read_byte(5'h05, d, ok);
    chk("month", {8'h00, d}, 16'h0003);
    rtcpc_host_inst.read_byte(5'h07, d, ok);
    chk("century", {8'h00, d}, 16'h0021);
    rtcpc_host_inst.read_byte(5'h00, s1, ok);
    repeat (120) @(posedge clk_sys);
    rtcpc_host_inst.read_byte(5'h00, d, ok);
    chk("frozen sec", {8'h00, d}, {8'h00, s1});
    rtcpc_host_inst.write_byte(5'h0f, 8'h01);
    rtcpc_host_inst.read_byte(5'h00, d, ok);
    chk("resumed sec", 16'(d == s1), 16'h0000);
    $display("calendar test done");
  endtask : t_calendar

  // Kick raises interrupt and power request, then routed to reset; software clears all.
  task automatic t_events;
    rtcpc_host_inst.write_byte(5'h0e, 8'h14);
    kick();
    chk("irq", {15'h0000, irq_oe}, 16'h0001);
    chk("pwr", {15'h0000, pwr_oe}, 16'h0001);
    rtcpc_host_inst.write_byte(5'h0f, 8'h73);
    chk("irq clr", {15'h0000, irq_oe}, 16'h0000);
    chk("pwr off", {15'h0000, pwr_oe}, 16'h0000);
    rtcpc_host_inst.write_byte(5'h0e, 8'h0c);
    kick();
    chk("rst evt", {14'h0000, rst_oe, irq_oe}, 16'h0002);
    rtcpc_host_inst.write_byte(5'h0f, 8'h71);
    chk("rst clr", {15'h0000, rst_oe}, 16'h0000);
    chk("od lows", {13'h0000, irq_out, rst_out, pwr_out}, 16'h0000);
    $display("event test done");
  endtask : t_events

  // Square wave half period measured edge to edge.
  task automatic t_sqw;
    rtcpc_host_inst.write_byte(5'h0e, 8'h40);
    for (n = 0; n < 4000 && square_wave_out !== 1'b1; n++)
      @(posedge clk_sys);
    for (n = 0; n < 4000 && square_wave_out === 1'b1; n++)
      @(posedge clk_sys);
    chk("sqw half", 16'(n), 16'(rtcpc_pkg::SQW_HALF_CYCLES));
    rtcpc_host_inst.write_byte(5'h0e, 8'h00);
    $display("square wave test done");
  endtask : t_sqw

  // Supply drop: SRAM gated, reset held, access refused; then the reset hold on return.
  task automatic t_power;
    @(posedge clk_sys);
    #1 pf = 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("sram gate", {14'h0000, sram_out_n, rst_oe}, 16'h0003);
    rtcpc_host_inst.read_byte(5'h11, d, ok);
    chk("refused", {15'h0000, ok}, 16'h0000);
    #1 pf = 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("still rst", {15'h0000, rst_oe}, 16'h0001);
    wait_release(10);
    chk("sram pass", {15'h0000, sram_out_n}, 16'h0000);
    $display("power test done");
  endtask : t_power

  // Free-running clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Watchdog against a hang, well above the expected run length.
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    bad_count = 0;
    cmp_count = 0;
    reset_n   = 1'b0;
    pf        = 1'b0;
    kick_n    = 1'b1;
    sram_in_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    wait_release(20);
    t_ram();
    t_calendar();
    t_events();
    t_sqw();
    t_power();
    give_verdict();
  end
endmodule : rtcpc_top_tb
